// ===== design/psu_output_pkg.sv
// Purpose: Shared constants for the supply output enable control block.
// Assumes: Registers are word wide and reached over the plain register port.
// Notes:   Offsets are byte addresses of 32-bit words.
package psu_output_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 32;
	localparam logic [7:0]  OFF_CTRL         = 8'h00;
	localparam logic [7:0]  OFF_STATUS       = 8'h04;
	localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h08;
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'h0c;
	localparam logic [7:0]  OFF_ID           = 8'h10;
	// Control fields.
	localparam int          CTRL_START_DIS   = 0;
	localparam int          CTRL_PARALLEL    = 1;
	// Status fields.
	localparam int          ST_OUT_EN        = 0;
	localparam int          ST_WC_INVALID    = 1;
	localparam int          ST_IN_OP         = 2;
	localparam int          ST_PDO_MAPPED    = 3;
	localparam int          ST_DIS_BIT       = 4;
	localparam int          ST_PARALLEL      = 5;
	// Interrupt events.
	localparam int          IRQ_W            = 3;
	localparam int          EV_OUT_CHANGE    = 0;
	localparam int          EV_WC_ERROR      = 1;
	localparam int          EV_ENTER_OP      = 2;
	// Reset values; a start-up default of zero means output enabled.
	localparam logic        START_DIS_RST    = 1'b0;
	localparam logic        PARALLEL_RST     = 1'b0;
	localparam logic        OUT_EN_RST       = 1'b0;
	localparam logic        WC_INVALID_RST   = 1'b1;
	localparam logic [2:0]  IRQ_MASK_RST     = 3'h0;
	// Arbitrary identification value.
	localparam logic [31:0] BLOCK_ID         = 32'h0000_a5c1;
endpackage : psu_output_pkg

// ===== design/psu_output_enable_control.sv
// Purpose: Decides the DC output enable from start-up default and cyclic disable bit.
// Assumes: Bus and link inputs are synchronised to clk upstream except the pins below.
// Notes:   sys_rst is the cold-start reset; a brief dip with live bus does not assert it.
// Function
// - Stored start-up default 0 enables output at power-up, 1 keeps it off.
// - Start-up default is applied only after a full cold start.
// - Short input dip with live bus keeps the last output state.
// - Shipped start-up default selects the output enabled.
// - Once in OP, the output follows the cyclic disable bit.
// - With the disable bit unmapped, reaching OP switches the output on.
// - Disable bit true holds output off; false restores it at once.
// - Working-counter flag reads 0 on good exchange, 1 on transfer error.
// - Paralleled operation is supported only while the parallel flag is 1.
`timescale 1ns/1ns
module psu_output_enable_control
	import psu_output_pkg::*;
(
	// Clock and reset.
	input  wire logic                             clk,
	input  wire logic                             sys_rst,
	// Register port.
	input  wire logic [psu_output_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [psu_output_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [psu_output_pkg::DATA_W-1:0] reg_rdata,
	// Slave state and cyclic exchange, from the bus controller pins.
	input  wire logic                             slave_in_op,
	input  wire logic                             pdo_mapped,
	input  wire logic                             disable_output,
	input  wire logic                             cycle_done,
	input  wire logic                             cycle_error,
	// Outputs to the power stage and the host.
	output logic                                  dc_output_enable,
	output logic                                  working_counter_invalid,
	output logic                                  parallel_use_enable,
	output logic                                  irq
);
	import psu_output_pkg::*;

	typedef enum logic [1:0] {ST_STARTUP, ST_OPERATE} mode_t;

	// Pin synchronisers: two flops, the first read only by the second.
	localparam int SYNC_W = 5;
	logic [SYNC_W-1:0] pin_meta_reg;
	logic [SYNC_W-1:0] pin_sync_reg;
	logic              in_op_s;
	logic              mapped_s;
	logic              dis_s;
	logic              cyc_done_s;
	logic              cyc_err_s;
	logic              cyc_done_d_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= {slave_in_op, pdo_mapped, disable_output, cycle_done,
				cycle_error};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign in_op_s    = pin_sync_reg[4];
	assign mapped_s   = pin_sync_reg[3];
	assign dis_s      = pin_sync_reg[2];
	assign cyc_done_s = pin_sync_reg[1];
	assign cyc_err_s  = pin_sync_reg[0];

	// Registers.
	logic             start_dis_reg;
	logic             parallel_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [IRQ_W-1:0] irq_event;
	mode_t            mode_reg;
	logic             out_en_next;
	logic             cycle_pulse;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_dis_reg <= START_DIS_RST;
			parallel_reg  <= PARALLEL_RST;
			irq_mask_reg  <= IRQ_MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				OFF_CTRL: begin
					start_dis_reg <= reg_wdata[CTRL_START_DIS];
					parallel_reg  <= reg_wdata[CTRL_PARALLEL];
				end
				OFF_IRQ_MASK: irq_mask_reg <= reg_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Mode leaves start-up only on OP; the start-up default is never re-applied
	// afterwards, because only a cold start (sys_rst) returns here.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= ST_STARTUP;
		end else begin
			case (mode_reg)
				ST_STARTUP: if (in_op_s) mode_reg <= ST_OPERATE;
				ST_OPERATE: mode_reg <= ST_OPERATE;
				default:    mode_reg <= ST_STARTUP;
			endcase
		end
	end

	always_comb begin
		if (mode_reg == ST_OPERATE || in_op_s) begin
			out_en_next = mapped_s ? ~dis_s : 1'b1;
		end else begin
			out_en_next = ~start_dis_reg;
		end
	end

	// Output holds through a brief dip since logic keeps running while the bus lives.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dc_output_enable <= OUT_EN_RST;
		end else begin
			dc_output_enable <= out_en_next;
		end
	end

	assign cycle_pulse = cyc_done_s & ~cyc_done_d_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc_done_d_reg          <= 1'b0;
			working_counter_invalid <= WC_INVALID_RST;
		end else begin
			cyc_done_d_reg <= cyc_done_s;
			if (cycle_pulse) begin
				working_counter_invalid <= cyc_err_s;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			parallel_use_enable <= PARALLEL_RST;
		end else begin
			parallel_use_enable <= parallel_reg;
		end
	end

	// Interrupts: set wins over write-one-to-clear.
	assign irq_event[EV_OUT_CHANGE] = out_en_next ^ dc_output_enable;
	assign irq_event[EV_WC_ERROR]   = cycle_pulse & cyc_err_s;
	assign irq_event[EV_ENTER_OP]   = (mode_reg == ST_STARTUP) & in_op_s;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status_reg <= '0;
		end else begin
			if (reg_wr && reg_addr == OFF_IRQ_STATUS) begin
				irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_W-1:0]) | irq_event;
			end else begin
				irq_status_reg <= irq_status_reg | irq_event;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				case (reg_addr)
					OFF_CTRL: begin
						reg_rdata[CTRL_START_DIS] <= start_dis_reg;
						reg_rdata[CTRL_PARALLEL]  <= parallel_reg;
					end
					OFF_STATUS: begin
						reg_rdata[ST_OUT_EN]     <= dc_output_enable;
						reg_rdata[ST_WC_INVALID] <= working_counter_invalid;
						reg_rdata[ST_IN_OP]      <= (mode_reg == ST_OPERATE);
						reg_rdata[ST_PDO_MAPPED] <= mapped_s;
						reg_rdata[ST_DIS_BIT]    <= dis_s;
						reg_rdata[ST_PARALLEL]   <= parallel_use_enable;
					end
					OFF_IRQ_STATUS: reg_rdata[IRQ_W-1:0] <= irq_status_reg;
					OFF_IRQ_MASK:   reg_rdata[IRQ_W-1:0] <= irq_mask_reg;
					OFF_ID:         reg_rdata <= BLOCK_ID;
					default:        reg_rdata <= '0;
				endcase
			end
		end
	end

	// Checks.
	sequence s_op_mapped_dis;
		(mode_reg == ST_OPERATE) && mapped_s && dis_s;
	endsequence

	property p_dis_holds_off;
		@(posedge clk) disable iff (sys_rst) s_op_mapped_dis |=> !dc_output_enable;
	endproperty
	a_dis_holds_off: assert property (p_dis_holds_off) else $error("output on while disabled");

	property p_unmapped_on;
		@(posedge clk) disable iff (sys_rst)
			(mode_reg == ST_OPERATE) && !mapped_s |=> dc_output_enable;
	endproperty
	a_unmapped_on: assert property (p_unmapped_on) else $error("output off unmapped in op");

	// The sampled reset keeps out the release edge, where the output still shows reset.
	property p_startup_default;
		@(posedge clk) disable iff (sys_rst)
			!sys_rst && (mode_reg == ST_STARTUP) && !in_op_s
			|=> dc_output_enable == ~$past(start_dis_reg);
	endproperty
	a_startup_default: assert property (p_startup_default) else $error("start-up default ignored");

	property p_op_sticky;
		@(posedge clk) disable iff (sys_rst) mode_reg == ST_OPERATE |=> mode_reg == ST_OPERATE;
	endproperty
	a_op_sticky: assert property (p_op_sticky) else $error("left operate mode");

	property p_enter_op;
		@(posedge clk) disable iff (sys_rst) in_op_s |=> mode_reg == ST_OPERATE;
	endproperty
	a_enter_op: assert property (p_enter_op) else $error("op not entered");

	property p_restore;
		@(posedge clk) disable iff (sys_rst)
			s_op_mapped_dis ##1 ((mode_reg == ST_OPERATE) && mapped_s && !dis_s)
			|=> dc_output_enable;
	endproperty
	a_restore: assert property (p_restore) else $error("output not restored");

	property p_wc_flag;
		@(posedge clk) disable iff (sys_rst)
			cycle_pulse |=> working_counter_invalid == $past(cyc_err_s);
	endproperty
	a_wc_flag: assert property (p_wc_flag) else $error("working counter flag wrong");

	property p_parallel;
		@(posedge clk) disable iff (sys_rst) ##1 parallel_use_enable == $past(parallel_reg);
	endproperty
	a_parallel: assert property (p_parallel) else $error("parallel flag mismatch");

	property p_op_law;
		@(posedge clk) disable iff (sys_rst)
			(mode_reg == ST_OPERATE) && mapped_s |=> dc_output_enable == ~$past(dis_s);
	endproperty
	a_op_law: assert property (p_op_law) else $error("op enable law broken");

	sequence s_ctrl_write;
		reg_wr && (reg_addr == OFF_CTRL);
	endsequence

	property p_start_dis_set;
		@(posedge clk) disable iff (sys_rst)
			s_ctrl_write ##0 reg_wdata[CTRL_START_DIS] |=> start_dis_reg;
	endproperty
	a_start_dis_set: assert property (p_start_dis_set) else $error("default not set");

	property p_start_dis_clr;
		@(posedge clk) disable iff (sys_rst)
			s_ctrl_write ##0 !reg_wdata[CTRL_START_DIS] |=> !start_dis_reg;
	endproperty
	a_start_dis_clr: assert property (p_start_dis_clr) else $error("default not cleared");

	property p_parallel_set;
		@(posedge clk) disable iff (sys_rst)
			s_ctrl_write ##0 reg_wdata[CTRL_PARALLEL] |=> parallel_reg;
	endproperty
	a_parallel_set: assert property (p_parallel_set) else $error("parallel not set");

	property p_parallel_clr;
		@(posedge clk) disable iff (sys_rst)
			s_ctrl_write ##0 !reg_wdata[CTRL_PARALLEL] |=> !parallel_reg;
	endproperty
	a_parallel_clr: assert property (p_parallel_clr) else $error("parallel not cleared");

	// A cold start must bring the output up at the shipped default.
	property p_cold_default;
		@(posedge clk) disable iff (sys_rst)
			$fell(sys_rst) |=> dc_output_enable == !START_DIS_RST;
	endproperty
	a_cold_default: assert property (p_cold_default) else $error("bad cold default");

	sequence s_enter_op;
		(mode_reg == ST_STARTUP) && in_op_s;
	endsequence

	property p_enter_op_event;
		@(posedge clk) disable iff (sys_rst)
			s_enter_op |=> irq_status_reg[EV_ENTER_OP] && (mode_reg == ST_OPERATE);
	endproperty
	a_enter_op_event: assert property (p_enter_op_event) else $error("op entry lost");

	property p_sync_delay;
		@(posedge clk) disable iff (sys_rst)
			$rose(slave_in_op) |-> ##2 in_op_s;
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("pin sync delay wrong");

	property p_wc_hold;
		@(posedge clk) disable iff (sys_rst)
			!cycle_pulse |=> $stable(working_counter_invalid);
	endproperty
	a_wc_hold: assert property (p_wc_hold) else $error("flag moved without cycle");

	// Set wins: an error in the clearing cycle must stay visible to the host.
	property p_wc_event;
		@(posedge clk) disable iff (sys_rst)
			irq_event[EV_WC_ERROR] |=> irq_status_reg[EV_WC_ERROR];
	endproperty
	a_wc_event: assert property (p_wc_event) else $error("error event lost");

	sequence s_clear_quiet;
		reg_wr && (reg_addr == OFF_IRQ_STATUS) && (reg_wdata[IRQ_W-1:0] == '1)
			&& (irq_event == '0);
	endsequence

	property p_clear_all;
		@(posedge clk) disable iff (sys_rst)
			s_clear_quiet |=> irq_status_reg == '0;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("status not cleared");

	property p_irq_on;
		@(posedge clk) disable iff (sys_rst)
			(irq_status_reg & irq_mask_reg) != '0 |=> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

	property p_irq_off;
		@(posedge clk) disable iff (sys_rst)
			(irq_status_reg & irq_mask_reg) == '0 |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

	property p_rdata_idle;
		@(posedge clk) disable iff (sys_rst)
			!reg_rd |=> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_read_id;
		@(posedge clk) disable iff (sys_rst)
			reg_rd && (reg_addr == OFF_ID) |=> reg_rdata == BLOCK_ID;
	endproperty
	a_read_id: assert property (p_read_id) else $error("identification read wrong");
endmodule : psu_output_enable_control

// ===== verification/fieldbus_master_model.sv
// Purpose: Bus master model driving the slave state and cyclic exchange pins.
// Assumes: Tasks are called just after a rising edge of clk.
// Notes:   Pins are levels; after their blocking initial values they change only by non-blocking assignment.
`timescale 1ns/1ns
module fieldbus_master_model (
	// Clock.
	input  wire logic clk,
	// Pins towards the device.
	output logic      slave_in_op,
	output logic      pdo_mapped,
	output logic      disable_output,
	output logic      cycle_done,
	output logic      cycle_error
);
	initial begin
		slave_in_op    = 1'b0;
		pdo_mapped     = 1'b0;
		disable_output = 1'b0;
		cycle_done     = 1'b0;
		cycle_error    = 1'b0;
	end
	// The map and the bit settle a cycle before OP, so the output never glitches on.
	task automatic go_op(input logic map, input logic dis);
		pdo_mapped     <= map;
		disable_output <= dis;
		@(posedge clk);
		slave_in_op    <= 1'b1;
	endtask : go_op
	task automatic set_dis(input logic dis);
		disable_output <= dis;
	endtask : set_dis
	task automatic drop();
		slave_in_op    <= 1'b0;
		pdo_mapped     <= 1'b0;
		disable_output <= 1'b0;
	endtask : drop
	// A failed exchange tells the host that the held data are stale.
	task automatic exchange(input logic err);
		cycle_error <= err;
		cycle_done  <= 1'b1;
		@(posedge clk);
		cycle_done  <= 1'b0;
		@(posedge clk);
	endtask : exchange
endmodule : fieldbus_master_model

// ===== verification/psu_output_enable_control_test.sv
// Purpose: Self-checking bench for the supply output enable control.
// Assumes: Pin changes reach the output within three edges.
// Notes:   Waits of five cycles leave margin over the synchroniser delay.
`timescale 1ns/1ns
module psu_output_enable_control_test;
	import psu_output_pkg::*;
	logic              clk, sys_rst, reg_wr, reg_rd, d;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
	logic              slave_in_op, pdo_mapped, disable_output, cycle_done, cycle_error;
	logic              dc_output_enable, working_counter_invalid, parallel_use_enable, irq;
	int                n_errors, checked;
	fieldbus_master_model master (.clk(clk), .slave_in_op(slave_in_op),
		.pdo_mapped(pdo_mapped), .disable_output(disable_output),
		.cycle_done(cycle_done), .cycle_error(cycle_error));
	psu_output_enable_control uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.slave_in_op(slave_in_op), .pdo_mapped(pdo_mapped),
		.disable_output(disable_output), .cycle_done(cycle_done),
		.cycle_error(cycle_error), .dc_output_enable(dc_output_enable),
		.working_counter_invalid(working_counter_invalid),
		.parallel_use_enable(parallel_use_enable), .irq(irq));
	always #25 clk = ~clk;
	function automatic logic exp_en(input logic op, input logic map, input logic dis,
		input logic sd);
		return op ? !(map && dis) : !sd;
	endfunction : exp_en
	function automatic logic [31:0] exp_status(input logic en, input logic wc, input logic op,
		input logic map, input logic dis, input logic par);
		logic [31:0] s;
		s                = 32'h0;
		s[ST_OUT_EN]     = en;
		s[ST_WC_INVALID] = wc;
		s[ST_IN_OP]      = op;
		s[ST_PDO_MAPPED] = map;
		s[ST_DIS_BIT]    = dis;
		s[ST_PARALLEL]   = par;
		return s;
	endfunction : exp_status
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd_reg
	task automatic settle();
		repeat (5) @(posedge clk);
	endtask : settle
	task automatic cold_reset();
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		settle();
	endtask : cold_reset
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		clk       = 1'b0;
		sys_rst   = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		n_errors  = 0;
		checked   = 0;
		void'($urandom(32'h293fd232));
		cold_reset();
		chk("out_en", 32'(exp_en(0, 0, 0, START_DIS_RST)), 32'(dc_output_enable));
		chk("wc_invalid", 32'h1, 32'(working_counter_invalid));
		rd_reg(OFF_CTRL, rd);
		chk("ctrl", {30'h0, PARALLEL_RST, START_DIS_RST}, rd);
		rd_reg(OFF_IRQ_MASK, rd);
		chk("mask", {29'h0, IRQ_MASK_RST}, rd);
		rd_reg(OFF_ID, rd);
		chk("id", BLOCK_ID, rd);
		rd_reg(8'h20, rd);
		chk("unmapped", 32'h0, rd);
		wr(OFF_CTRL, 32'h3);
		settle();
		chk("out_en", 32'(exp_en(0, 0, 0, 1)), 32'(dc_output_enable));
		chk("parallel", 32'h1, 32'(parallel_use_enable));
		master.exchange(1'b0);
		settle();
		chk("wc_invalid", 32'h0, 32'(working_counter_invalid));
		master.exchange(1'b1);
		settle();
		chk("wc_invalid", 32'h1, 32'(working_counter_invalid));
		chk("irq_masked", 32'h0, 32'(irq));
		wr(OFF_IRQ_MASK, 32'h1 << EV_ENTER_OP);
		master.go_op(1'b0, 1'b1);
		settle();
		chk("out_en", 32'(exp_en(1, 0, 1, 1)), 32'(dc_output_enable));
		chk("irq", 32'h1, 32'(irq));
		rd_reg(OFF_STATUS, rd);
		chk("status", exp_status(exp_en(1, 0, 1, 1), 1'b1, 1'b1, 1'b0, 1'b1, 1'b1), rd);
		rd_reg(OFF_IRQ_STATUS, rd);
		chk("irq_op", 32'h1, 32'(rd[EV_ENTER_OP]));
		chk("irq_all", (32'h1 << EV_OUT_CHANGE) | (32'h1 << EV_WC_ERROR) | (32'h1 << EV_ENTER_OP),
			rd);
		wr(OFF_IRQ_STATUS, 32'h7);
		settle();
		chk("irq_clr", 32'h0, 32'(irq));
		rd_reg(OFF_IRQ_STATUS, rd);
		chk("irq_st_clr", 32'h0, rd);
		master.drop();
		cold_reset();
		chk("out_en", 32'(exp_en(0, 0, 0, START_DIS_RST)), 32'(dc_output_enable));
		chk("parallel", 32'(PARALLEL_RST), 32'(parallel_use_enable));
		chk("wc_invalid", 32'h1, 32'(working_counter_invalid));
		wr(OFF_CTRL, 32'h1);
		master.go_op(1'b1, 1'b1);
		settle();
		chk("out_en", 32'(exp_en(1, 1, 1, 1)), 32'(dc_output_enable));
		wr(OFF_CTRL, 32'h0);
		settle();
		chk("out_en", 32'h0, 32'(dc_output_enable));
		rd_reg(OFF_STATUS, rd);
		chk("status", exp_status(exp_en(1, 1, 1, 1), 1'b1, 1'b1, 1'b1, 1'b1, 1'b0), rd);
		for (int i = 0; i < 12; i++) begin
			d = 1'($urandom);
			master.set_dis(d);
			settle();
			chk("out_en", 32'(exp_en(1, 1, d, 1)), 32'(dc_output_enable));
		end
		tally_and_finish();
	end
endmodule : psu_output_enable_control_test
